// ### rtl/eirp_pkg.sv
/*
 * Shared constants and types for the external interrupt request port.
 * Assumes one core clock and an active-low asynchronous core reset.
 */
package eirp_pkg;
	// ==========================================================
	// Vector offsets
	localparam logic [15:0] VEC_CRIT    = 16'h0100;
	localparam logic [15:0] VEC_NONCRIT = 16'h0200;

	// ==========================================================
	// Reset values and field positions
	localparam logic        RST_ENABLE  = 1'h0;
	localparam logic [31:0] RST_PC      = 32'h0000_0000;
	localparam logic [31:0] RST_STATE   = 32'h0000_0000;
	localparam int          MSR_CE_BIT  = 1;
	localparam int          MSR_EE_BIT  = 0;
	localparam int          N_SOURCES   = 8;

	// ==========================================================
	// Handler state of the core end
	typedef enum logic [1:0] {
		CTX_IDLE    = 2'b00,
		CTX_NONCRIT = 2'b01,
		CTX_CRIT    = 2'b10,
		CTX_NESTED  = 2'b11
	} eirp_ctx_e;
endpackage

// ### rtl/eirp_if.sv
/*
 * Carrier joining the interrupt collector to the core request port.
 * Assumes both ends run on the same core clock.
 */
interface eirp_if;
	logic critIrqRequestIn;
	logic noncritIrqRequestIn;

	modport core
	(
		input critIrqRequestIn,
		input noncritIrqRequestIn
	);
	modport collector
	(
		output critIrqRequestIn,
		output noncritIrqRequestIn
	);
endinterface

// ### rtl/eirp_sync.sv
/*
 * Two-flop level synchroniser for one request line.
 * Assumes an asynchronous level input; output is quiet low after reset.
 */
module eirp_sync
(
	// Clock and reset
	input  wire logic mclk,
	input  wire logic nrst,
	// Level in and out
	input  wire logic din,
	output logic      dout
);
	typedef struct packed {
		logic meta;
		logic sync;
	} eirp_sync_s;

	eirp_sync_s st_r;
	eirp_sync_s st_nxt;

	always_comb
	begin
		st_nxt.meta = din;
		st_nxt.sync = st_r.meta;
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	assign dout = st_r.sync;
endmodule

// ### rtl/eirp_core_port.sv
/*
 * Core end of the external interrupt request port: gating by the
 * machine-state enables, priority, save/restore pairs and vectoring.
 * Assumes the collector holds requests high until software clears them.
 */
// Operation
// - Critical interrupt branches to offset 0x0100
// - Noncritical interrupt branches to offset 0x0200
// - Critical ranks above noncritical; debug below critical
// - Critical saves pair two, noncritical pair one
// - Critical preempts noncritical handler, noncritical save intact
// - Collector holds request until software clears it
// - Noncritical taken only while its enable is 1
// - Critical taken only while its enable is 1
// - Both enable bits shown on power interface
// - Disabled request stays pending, taken when enabled
// - Collector merges requests into two lines
// - High line means request, low means none
// - Unused critical input tied to 0
// - Unused noncritical input tied to 0
module eirp_core_port
(
	// Clock and reset
	input  wire logic  mclk,
	input  wire logic  nrst,
	// Request lines from the collector
	eirp_if.core       irq,
	// Machine state and program counter
	input  wire logic  msrWrite,
	input  wire logic  critIrqEnableIn,
	input  wire logic  noncritIrqEnableIn,
	input  wire logic [31:0] curPc,
	input  wire logic [31:0] curState,
	// Handler returns
	input  wire logic  critReturn,
	input  wire logic  noncritReturn,
	// Debug event of lower rank than critical
	input  wire logic  debugReq,
	// Vectoring
	output logic       takeIrq,
	output logic [15:0] vectorOffset,
	output logic       debugTake,
	// Power management reflection of enables
	output logic       critIrqEnable,
	output logic       noncritIrqEnable,
	// Save/restore pairs
	output logic [31:0] noncritSavePc,
	output logic [31:0] noncritSaveState,
	output logic [31:0] critSavePc,
	output logic [31:0] critSaveState,
	output eirp_pkg::eirp_ctx_e ctxState
);
	typedef struct packed {
		logic                ce;
		logic                ee;
		logic                take;
		logic [15:0]         vec;
		logic                dbg;
		logic [31:0]         ncPc;
		logic [31:0]         ncSt;
		logic [31:0]         crPc;
		logic [31:0]         crSt;
		eirp_pkg::eirp_ctx_e ctx;
	} eirp_core_s;

	eirp_core_s st_r;
	eirp_core_s st_nxt;
	logic       critLvl;
	logic       noncritLvl;
	logic       critGo;
	logic       noncritGo;
	logic [31:0] savedState;

	// ==========================================================
	// Input synchronisers
	// sampled request levels
	eirp_sync u_syncCrit
	(
		.mclk (mclk),
		.nrst (nrst),
		.din  (irq.critIrqRequestIn),
		.dout (critLvl)
	);
	eirp_sync u_syncNoncrit
	(
		.mclk (mclk),
		.nrst (nrst),
		.din  (irq.noncritIrqRequestIn),
		.dout (noncritLvl)
	);

	// ==========================================================
	// Acceptance and priority
	always_comb
	begin
		critGo = critLvl && st_r.ce;
		noncritGo = noncritLvl && st_r.ee;
		savedState = curState;
		savedState[eirp_pkg::MSR_CE_BIT] = st_r.ce;
		savedState[eirp_pkg::MSR_EE_BIT] = st_r.ee;

		st_nxt = st_r;
		st_nxt.take = 1'b0;
		st_nxt.dbg = 1'b0;
		if (msrWrite)
		begin
			st_nxt.ce = critIrqEnableIn;
			st_nxt.ee = noncritIrqEnableIn;
		end
		if (critReturn && st_r.ctx[1])
		begin
			st_nxt.ce = st_r.crSt[eirp_pkg::MSR_CE_BIT];
			st_nxt.ee = st_r.crSt[eirp_pkg::MSR_EE_BIT];
			st_nxt.ctx = (st_r.ctx == eirp_pkg::CTX_NESTED) ? eirp_pkg::CTX_NONCRIT : eirp_pkg::CTX_IDLE;
		end
		else if (noncritReturn && st_r.ctx == eirp_pkg::CTX_NONCRIT)
		begin
			st_nxt.ce = st_r.ncSt[eirp_pkg::MSR_CE_BIT];
			st_nxt.ee = st_r.ncSt[eirp_pkg::MSR_EE_BIT];
			st_nxt.ctx = eirp_pkg::CTX_IDLE;
		end
		else if (critGo)
		begin
			st_nxt.take = 1'b1;
			st_nxt.vec = eirp_pkg::VEC_CRIT;
			st_nxt.crPc = curPc;
			st_nxt.crSt = savedState;
			st_nxt.ce = 1'b0;
			st_nxt.ee = 1'b0;
			st_nxt.ctx = (st_r.ctx == eirp_pkg::CTX_NONCRIT) ? eirp_pkg::CTX_NESTED : eirp_pkg::CTX_CRIT;
		end
		else if (debugReq)
			st_nxt.dbg = 1'b1;
		else if (noncritGo)
		begin
			st_nxt.take = 1'b1;
			st_nxt.vec = eirp_pkg::VEC_NONCRIT;
			st_nxt.ncPc = curPc;
			st_nxt.ncSt = savedState;
			st_nxt.ee = 1'b0;
			st_nxt.ctx = eirp_pkg::CTX_NONCRIT;
		end
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
		begin
			st_r.ce   <= eirp_pkg::RST_ENABLE;
			st_r.ee   <= eirp_pkg::RST_ENABLE;
			st_r.take <= 1'b0;
			st_r.vec  <= 16'h0000;
			st_r.dbg  <= 1'b0;
			st_r.ncPc <= eirp_pkg::RST_PC;
			st_r.ncSt <= eirp_pkg::RST_STATE;
			st_r.crPc <= eirp_pkg::RST_PC;
			st_r.crSt <= eirp_pkg::RST_STATE;
			st_r.ctx  <= eirp_pkg::CTX_IDLE;
		end
		else
			st_r <= st_nxt;
	end

	// ==========================================================
	// Outputs
	assign takeIrq          = st_r.take;
	assign vectorOffset     = st_r.vec;
	assign debugTake        = st_r.dbg;
	assign critIrqEnable    = st_r.ce;
	assign noncritIrqEnable = st_r.ee;
	assign noncritSavePc    = st_r.ncPc;
	assign noncritSaveState = st_r.ncSt;
	assign critSavePc       = st_r.crPc;
	assign critSaveState    = st_r.crSt;
	assign ctxState         = st_r.ctx;
endmodule

// ### rtl/eirp_collector.sv
/*
 * Collector end: merges peripheral requests into one critical and one
 * noncritical line, each held until software clears it.
 * Assumes peripheral requests are on the core clock.
 */
module eirp_collector
#(
	parameter int NSRC = eirp_pkg::N_SOURCES
)
(
	// Clock and reset
	input  wire logic            mclk,
	input  wire logic            nrst,
	// Request lines to the core
	eirp_if.collector            irq,
	// Peripheral events and class select
	input  wire logic [NSRC-1:0] srcEvent,
	input  wire logic [NSRC-1:0] srcIsCrit,
	// Software clear of pending sources
	input  wire logic            clrWrite,
	input  wire logic [NSRC-1:0] clrMask,
	// Pending view
	output logic [NSRC-1:0]      pending
);
	typedef struct packed {
		logic [NSRC-1:0] pend;
		logic [NSRC-1:0] crit;
	} eirp_coll_s;

	eirp_coll_s st_r;
	eirp_coll_s st_nxt;

	always_comb
	begin
		st_nxt = st_r;
		// held until cleared; set beats clear
		if (clrWrite)
			st_nxt.pend = st_r.pend & ~clrMask;
		st_nxt.pend = st_nxt.pend | srcEvent;
		st_nxt.crit = (st_r.crit & ~srcEvent) | (srcIsCrit & srcEvent);
	end

	always_ff @(posedge mclk or negedge nrst)
	begin
		if (!nrst)
			st_r <= '0;
		else
			st_r <= st_nxt;
	end

	// merge into two lines; low when idle
	assign irq.critIrqRequestIn    = |(st_r.pend & st_r.crit);
	assign irq.noncritIrqRequestIn = |(st_r.pend & ~st_r.crit);
	assign pending                 = st_r.pend;
endmodule

// ### test/eirp_sva.sv
/* Checker for the request port: ties takes to enables and lines.
   Assumes it sits beside the carrier in the bench top. */
module eirp_sva
(
	// Clock and reset
	input wire logic        mclk,
	input wire logic        nrst,
	// Carrier lines and clear
	input wire logic        critIrqRequestIn,
	input wire logic        noncritIrqRequestIn,
	input wire logic        clrWrite,
	// Core outputs
	input wire logic        takeIrq,
	input wire logic [15:0] vectorOffset,
	input wire logic        critIrqEnable,
	input wire logic        noncritIrqEnable,
	input wire logic [31:0] noncritSavePc
);
	timeunit 1ns;
	timeprecision 1ns;
	wire isCrit = takeIrq && vectorOffset == eirp_pkg::VEC_CRIT;
	wire isNc   = takeIrq && vectorOffset == eirp_pkg::VEC_NONCRIT;
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	crit_gate_a: assert property (isCrit |-> $past(critIrqEnable))
		else $error("critical taken while disabled");
	nc_gate_a: assert property (isNc |-> $past(noncritIrqEnable))
		else $error("noncritical taken while disabled");
	crit_clear_a: assert property (isCrit |-> !critIrqEnable && !noncritIrqEnable)
		else $error("enables left set after critical take");
	nc_clear_a: assert property (isNc |-> !noncritIrqEnable)
		else $error("enable left set after noncritical take");
	take_pulse_a: assert property (takeIrq |=> !takeIrq)
		else $error("take longer than one cycle");
	crit_line_a: assert property (isCrit |-> $past(critIrqRequestIn, 2))
		else $error("critical take without request");
	nc_line_a: assert property (isNc |-> $past(noncritIrqRequestIn, 2))
		else $error("noncritical take without request");
	held_line_a: assert property ($fell(critIrqRequestIn) || $fell(noncritIrqRequestIn) |-> $past(clrWrite))
		else $error("request dropped without clear");
	nc_kept_a: assert property (isCrit |-> $stable(noncritSavePc))
		else $error("noncritical save lost");
endmodule

// ### test/eirp_tb.sv
/* Bench for collector and core joined by the carrier.
   Assumes the package and both ends are compiled first. */
module eirp_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic mclk = 1'h0, nrst = 1'h0, msrWrite = 1'h0, critIrqEnableIn = 1'h0, noncritIrqEnableIn = 1'h0;
	logic critReturn = 1'h0, noncritReturn = 1'h0, debugReq = 1'h0, clrWrite = 1'h0;
	logic [31:0] curPc = 32'h0, curState = 32'h0;
	logic [7:0] srcEvent = 8'h00, srcIsCrit = 8'h00, clrMask = 8'h00, pending;
	logic takeIrq, debugTake, critIrqEnable, noncritIrqEnable;
	logic [15:0] vectorOffset;
	logic [31:0] noncritSavePc, noncritSaveState, critSavePc, critSaveState;
	eirp_pkg::eirp_ctx_e ctxState;
	int nErrors = 0, nChecks = 0;
	eirp_if irq();
	eirp_collector u_eirp_collector(.*);
	eirp_core_port u_eirp_core_port(.*);
	eirp_sva u_eirp_sva(.critIrqRequestIn(irq.critIrqRequestIn), .noncritIrqRequestIn(irq.noncritIrqRequestIn), .*);
	always #10 mclk = ~mclk;
	task automatic chk(logic [31:0] seen, logic [31:0] exp);
		nChecks++;
		if (seen !== exp)
		begin
			nErrors++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task automatic finishTest();
		$display("errors %0d checks %0d", nErrors, nChecks);
		if (nErrors == 0 && nChecks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic machine_state_reg(logic c, logic n, logic [31:0] pc);
		@(posedge mclk);
		critIrqEnableIn <= c;
		noncritIrqEnableIn <= n;
		curPc <= pc;
		msrWrite <= 1'h1;
		@(posedge mclk);
		msrWrite <= 1'h0;
	endtask
	task automatic raise(logic [7:0] ev, logic [7:0] cr);
		@(posedge mclk);
		srcEvent <= ev;
		srcIsCrit <= cr;
		@(posedge mclk);
		srcEvent <= 8'h00;
	endtask
	task automatic clr(logic [7:0] m);
		@(posedge mclk);
		clrWrite <= 1'h1;
		clrMask <= m;
		@(posedge mclk);
		clrWrite <= 1'h0;
		repeat (4) @(posedge mclk);
	endtask
	task automatic ret(logic crit);
		@(posedge mclk);
		critReturn <= crit;
		noncritReturn <= !crit;
		@(posedge mclk);
		critReturn <= 1'h0;
		noncritReturn <= 1'h0;
	endtask
	task automatic waitTake(logic [15:0] vec);
		int i;
		for (i = 0; i < 20; i++)
		begin
			@(negedge mclk);
			if (takeIrq === 1'h1)
				break;
		end
		if (i == 20)
		begin
			nErrors++;
			finishTest();
		end
		chk(32'(vectorOffset), 32'(vec));
	endtask
	initial
	begin
		repeat (5) @(posedge mclk);
		nrst <= 1'h1;
		// Disabled class stays pending
		raise(8'h02, 8'h00);
		repeat (6) @(posedge mclk);
		chk(32'(pending), 32'h2);
		chk(32'(ctxState), 32'(eirp_pkg::CTX_IDLE));
		machine_state_reg(1'h0, 1'h1, 32'h1000);
		waitTake(16'h0200);
		chk(noncritSavePc, 32'h1000);
		chk(32'(noncritIrqEnable), 32'h0);
		chk(noncritSaveState, 32'h1);
		// Critical preempts noncritical handler
		machine_state_reg(1'h1, 1'h0, 32'h2000);
		raise(8'h01, 8'h01);
		waitTake(16'h0100);
		chk(critSavePc, 32'h2000);
		chk(noncritSavePc, 32'h1000);
		chk(32'(ctxState), 32'(eirp_pkg::CTX_NESTED));
		chk(32'(critIrqEnable), 32'h0);
		chk(critSaveState, 32'h2);
		clr(8'h03);
		ret(1'h1);
		ret(1'h0);
		@(negedge mclk);
		chk(32'(ctxState), 32'(eirp_pkg::CTX_IDLE));
		// Simultaneous requests
		machine_state_reg(1'h0, 1'h0, 32'h3000);
		raise(8'h0C, 8'h04);
		repeat (4) @(posedge mclk);
		machine_state_reg(1'h1, 1'h1, 32'h4000);
		waitTake(16'h0100);
		clr(8'h04);
		ret(1'h1);
		waitTake(16'h0200);
		chk(noncritSavePc, 32'h4000);
		// Debug event taken when no critical request
		@(posedge mclk);
		debugReq <= 1'h1;
		@(posedge mclk);
		debugReq <= 1'h0;
		@(negedge mclk);
		chk(32'(debugTake), 32'h1);
		chk(32'(takeIrq), 32'h0);
		finishTest();
	end
endmodule
